// *** canf_regs.svh ***
// Purpose: Register offsets, reset values and filter constants of the acceptance filter
// Assumes: 4-bit byte address, 8-bit register data
// Notes: Definitions only
`ifndef CANF_REGS_SVH
`define CANF_REGS_SVH

`define CANF_ADDR_W 4
`define CANF_DATA_W 8

`define CANF_OFS_CODE0 4'h0
`define CANF_OFS_CODE1 4'h1
`define CANF_OFS_CODE2 4'h2
`define CANF_OFS_CODE3 4'h3
`define CANF_OFS_MASK0 4'h4
`define CANF_OFS_MASK1 4'h5
`define CANF_OFS_MASK2 4'h6
`define CANF_OFS_MASK3 4'h7
`define CANF_OFS_CTRL 4'h8
`define CANF_OFS_STAT 4'h9
`define CANF_OFS_ACC_CNT 4'hA
`define CANF_OFS_REJ_CNT 4'hB

`define CANF_CODE_RST 8'h00
`define CANF_MASK_RST 8'hFF
`define CANF_CTRL_CLR_BIT 0
`define CANF_STAT_ACC_BIT 0
`define CANF_STAT_EXT_BIT 1
`define CANF_STAT_RTR_BIT 2

`define CANF_STD_IGN 32'h000F_0000
`define CANF_EXT_IGN 32'h0000_0003

`endif

// *** canf_pkg.sv ***
// Purpose: Types shared by the acceptance filter
// Assumes: Frames arrive already decoded from the CAN receiver
// Notes: Constants live in canf_regs.svh
package canf_pkg;

    typedef struct packed {
        logic ide;
        logic rtr;
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } canf_frame_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } canf_bus_req_type;

endpackage : canf_pkg

// *** canf_byte_cmp.sv ***
// Purpose: One byte lane of the acceptance compare
// Assumes: Mask bit one or ignore bit one removes the bit from the check
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module canf_byte_cmp #(
    parameter int W = 8
) (
    input wire logic [W-1:0] code,
    input wire logic [W-1:0] mask,
    input wire logic [W-1:0] ignore,
    input wire logic [W-1:0] value,
    output logic match
);
    assign match = &(~(code ^ value) | mask | ignore);
endmodule : canf_byte_cmp

`default_nettype wire

// *** canf_filter.sv ***
// Purpose: Acceptance filter between the CAN receiver and the host receive path
// Assumes: One decoded frame per rx_valid pulse; identifier left aligned in id[28:18] for standard frames
// Notes: Decision and delivery one cycle after rx_valid
// Function
// - Four code and four mask bytes
// - Mask zero checks bit, one ignores it
// - Deliver only frames where all checked bits match
// - Standard: byte zero checks ID.28 to ID.21
// - Standard: byte one upper nibble ID.20-18, RTR
// - Standard: bytes two, three check data bytes
// - Extended: low two bits of byte three ignored
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "canf_regs.svh"

module canf_filter #(
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire canf_pkg::canf_bus_req_type bus,
    output logic [7:0] rd_data,
    input wire logic rx_valid,
    input wire canf_pkg::canf_frame_type rx_frame,
    output logic host_valid,
    output canf_pkg::canf_frame_type host_frame,
    output logic reject_pulse
);
    import canf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] code_reg [4];
    logic [7:0] mask_reg [4];
    logic [31:0] code_all;
    logic [31:0] mask_all;
    logic [31:0] frame_bits;
    logic [31:0] ign_bits;
    logic [3:0] byte_match;
    logic frame_match;
    logic clr_cnt;
    logic host_valid_reg;
    logic reject_reg;
    canf_frame_type host_frame_reg;
    logic [CNT_W-1:0] acc_cnt_reg;
    logic [CNT_W-1:0] rej_cnt_reg;
    logic [2:0] stat_reg;
    logic [7:0] rd_next;
    logic [7:0] rd_data_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Code and mask registers

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                code_reg[i] <= `CANF_CODE_RST;
                mask_reg[i] <= `CANF_MASK_RST;
            end
        end else if (bus.wr) begin
            case (bus.addr)
                `CANF_OFS_CODE0: code_reg[0] <= bus.wdata;
                `CANF_OFS_CODE1: code_reg[1] <= bus.wdata;
                `CANF_OFS_CODE2: code_reg[2] <= bus.wdata;
                `CANF_OFS_CODE3: code_reg[3] <= bus.wdata;
                `CANF_OFS_MASK0: mask_reg[0] <= bus.wdata;
                `CANF_OFS_MASK1: mask_reg[1] <= bus.wdata;
                `CANF_OFS_MASK2: mask_reg[2] <= bus.wdata;
                `CANF_OFS_MASK3: mask_reg[3] <= bus.wdata;
                default: begin
                end
            endcase
        end
    end

    assign code_all = {code_reg[0], code_reg[1], code_reg[2], code_reg[3]};
    assign mask_all = {mask_reg[0], mask_reg[1], mask_reg[2], mask_reg[3]};
    assign clr_cnt = bus.wr && (bus.addr == `CANF_OFS_CTRL) && bus.wdata[`CANF_CTRL_CLR_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Frame bit layout seen by the filter, byte zero in the top byte

    always_comb begin
        if (!rx_frame.ide) begin
            frame_bits = {rx_frame.id[28:21],
                          rx_frame.id[20:18], rx_frame.rtr, 4'h0,
                          rx_frame.data[63:56], rx_frame.data[55:48]};
            ign_bits = `CANF_STD_IGN;
        end else begin
            frame_bits = {rx_frame.id, rx_frame.rtr, 2'b00};
            ign_bits = `CANF_EXT_IGN;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_lane
        canf_byte_cmp #(
            .W(8)
        ) u_cmp (
            .code(code_reg[g]),
            .mask(mask_reg[g]),
            .ignore(ign_bits[31-8*g -: 8]),
            .value(frame_bits[31-8*g -: 8]),
            .match(byte_match[g])
        );
    end

    assign frame_match = &byte_match;

    ////////////////////////////////////////////////////////////////////////////////
    // Delivery to the host receive path

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_valid_reg <= 1'b0;
            reject_reg <= 1'b0;
        end else begin
            host_valid_reg <= rx_valid && frame_match;
            reject_reg <= rx_valid && !frame_match;
        end
    end

    // Rejected frames never reach the output data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_frame_reg <= '0;
        end else if (rx_valid && frame_match) begin
            host_frame_reg <= rx_frame;
        end
    end

    assign host_valid = host_valid_reg;
    assign reject_pulse = reject_reg;
    assign host_frame = host_frame_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Statistics; an event in the clearing cycle still counts

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_cnt_reg <= '0;
        end else if (host_valid_reg) begin
            acc_cnt_reg <= clr_cnt ? CNT_W'(1) : acc_cnt_reg + CNT_W'(1);
        end else if (clr_cnt) begin
            acc_cnt_reg <= '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rej_cnt_reg <= '0;
        end else if (reject_reg) begin
            rej_cnt_reg <= clr_cnt ? CNT_W'(1) : rej_cnt_reg + CNT_W'(1);
        end else if (clr_cnt) begin
            rej_cnt_reg <= '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_reg <= 3'h0;
        end else if (rx_valid) begin
            stat_reg[`CANF_STAT_ACC_BIT] <= frame_match;
            stat_reg[`CANF_STAT_EXT_BIT] <= rx_frame.ide;
            stat_reg[`CANF_STAT_RTR_BIT] <= rx_frame.rtr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port, data valid only in the cycle after the strobe

    always_comb begin
        rd_next = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `CANF_OFS_CODE0: rd_next = code_reg[0];
                `CANF_OFS_CODE1: rd_next = code_reg[1];
                `CANF_OFS_CODE2: rd_next = code_reg[2];
                `CANF_OFS_CODE3: rd_next = code_reg[3];
                `CANF_OFS_MASK0: rd_next = mask_reg[0];
                `CANF_OFS_MASK1: rd_next = mask_reg[1];
                `CANF_OFS_MASK2: rd_next = mask_reg[2];
                `CANF_OFS_MASK3: rd_next = mask_reg[3];
                `CANF_OFS_STAT: rd_next = {5'h00, stat_reg};
                `CANF_OFS_ACC_CNT: rd_next = 8'(acc_cnt_reg);
                `CANF_OFS_REJ_CNT: rd_next = 8'(rej_cnt_reg);
                default: rd_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_next;
        end
    end

    assign rd_data = rd_data_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!nrst);

    logic [29:0] ext_diff;
    logic std_all_open;

    assign ext_diff = ({rx_frame.id, rx_frame.rtr} ^ code_all[31:2]) & ~mask_all[31:2];
    assign std_all_open = (mask_reg[0] == 8'hFF) && (mask_reg[1][7:4] == 4'hF) &&
                          (mask_reg[2] == 8'hFF) && (mask_reg[3] == 8'hFF);

    reg_readback_a: assert property (
        bus.wr && bus.addr == `CANF_OFS_CODE2 ##1 bus.rd && bus.addr == `CANF_OFS_CODE2 && !bus.wr
        |=> rd_data == $past(bus.wdata, 2))
        else $error("code byte readback mismatch");

    mask_open_a: assert property (
        rx_valid && mask_all == 32'hFFFF_FFFF |=> host_valid && !reject_pulse)
        else $error("fully masked frame not delivered");

    frame_copy_a: assert property (
        host_valid |-> host_frame == $past(rx_frame))
        else $error("delivered frame differs from received frame");

    no_frame_quiet_a: assert property (
        !rx_valid |=> !host_valid && !reject_pulse)
        else $error("output pulse without a received frame");

    result_exclusive_a: assert property (
        rx_valid |=> host_valid != reject_pulse)
        else $error("frame both accepted and rejected");

    std_id_high_a: assert property (
        rx_valid && !rx_frame.ide && mask_reg[0] == 8'h00 && code_reg[0] != rx_frame.id[28:21]
        |=> reject_pulse && !host_valid)
        else $error("standard upper identifier mismatch accepted");

    std_nibble_ign_a: assert property (
        rx_valid && !rx_frame.ide && std_all_open |=> host_valid)
        else $error("standard frame blocked by unused nibble");

    std_rtr_bit_a: assert property (
        rx_valid && !rx_frame.ide && std_all_open == 1'b0 && mask_reg[1][4] == 1'b0 &&
        code_reg[1][4] != rx_frame.rtr |=> reject_pulse)
        else $error("standard RTR mismatch accepted");

    std_data_a: assert property (
        rx_valid && !rx_frame.ide && mask_reg[3] == 8'h00 && code_reg[3] != rx_frame.data[55:48]
        |=> reject_pulse)
        else $error("second data byte mismatch accepted");

    ext_match_a: assert property (
        rx_valid && rx_frame.ide && ext_diff == 30'h0 |=> host_valid)
        else $error("matching extended frame rejected");

    ext_rtr_pos_a: assert property (
        rx_valid && rx_frame.ide && mask_all[2] == 1'b0 && code_all[2] != rx_frame.rtr
        |=> reject_pulse)
        else $error("extended RTR mismatch accepted");

    ext_msb_first_a: assert property (
        rx_valid && rx_frame.ide && mask_all[31] == 1'b0 && code_all[31] != rx_frame.id[28]
        |=> reject_pulse)
        else $error("extended ID.28 mismatch accepted");

    rd_idle_zero_a: assert property (
        !bus.rd |=> rd_data == 8'h00)
        else $error("read data present without a read strobe");

    reject_hold_a: assert property (
        reject_pulse |-> $stable(host_frame))
        else $error("rejected frame reached the host output");

    acc_set_wins_a: assert property (
        host_valid && clr_cnt |=> acc_cnt_reg == CNT_W'(1))
        else $error("counter clear hid an accepted frame");

    std_accept_c: cover property (rx_valid && !rx_frame.ide ##1 host_valid);

    ext_accept_c: cover property (rx_valid && rx_frame.ide ##1 host_valid);

    reject_c: cover property (rx_valid ##1 reject_pulse);

    clear_on_event_c: cover property (host_valid && clr_cnt);

endmodule : canf_filter

`default_nettype wire

// *** canf_node_model.sv ***
// Purpose: Remote CAN node handing decoded frames to the filter
// Assumes: One frame per send pulse, shown for one cycle
// Notes: Frame lines toggle while idle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module canf_node_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic send,
    input wire canf_pkg::canf_frame_type frame_in,
    output logic rx_valid,
    output canf_pkg::canf_frame_type rx_frame
);
    import canf_pkg::*;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_valid <= 1'b0;
            rx_frame <= '0;
        end else if (send) begin
            rx_valid <= 1'b1;
            rx_frame <= frame_in;
        end else begin
            rx_valid <= 1'b0;
            rx_frame <= ~rx_frame;
        end
    end
endmodule : canf_node_model
`default_nettype wire

// *** can_acceptance_filter_tb.sv ***
// Purpose: Self-checking bench of the acceptance filter
// Assumes: Register bus answers one cycle after the read strobe
// Notes: Each filter bit is flipped in turn for both frame formats
`timescale 1ns/1ps
`default_nettype none
`include "canf_regs.svh"
module can_acceptance_filter_tb;
    import canf_pkg::*;
    logic clock;
    logic nrst;
    canf_bus_req_type bus;
    logic [7:0] rd_data;
    logic rx_valid;
    canf_frame_type rx_frame;
    logic host_valid;
    canf_frame_type host_frame;
    logic reject_pulse;
    logic send;
    canf_frame_type frame_in;
    canf_frame_type last_acc;
    int errors;
    int samples_checked;

    canf_filter #(.CNT_W(8)) dut_u (.clock(clock), .nrst(nrst), .bus(bus), .rd_data(rd_data),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .host_valid(host_valid), .host_frame(host_frame),
        .reject_pulse(reject_pulse));
    canf_node_model node_u (.clock(clock), .nrst(nrst), .send(send), .frame_in(frame_in),
        .rx_valid(rx_valid), .rx_frame(rx_frame));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte
    task automatic check_frame(input string what, input canf_frame_type exp, input canf_frame_type got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check_frame
    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd_check(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        check_byte("rd_data", exp, rd_data);
    endtask : bus_rd_check
    task automatic bus_wr_rd_check(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        check_byte("rd_data", d, rd_data);
        @(posedge clock);
        #1;
        check_byte("rd_data idle", 8'h00, rd_data);
    endtask : bus_wr_rd_check
    task automatic set_filter(input logic [31:0] c, input logic [31:0] m);
        for (int i = 0; i < 4; i++) begin
            bus_wr(`CANF_OFS_CODE0 + 4'(i), c[31-8*i -: 8]);
            bus_wr(`CANF_OFS_MASK0 + 4'(i), m[31-8*i -: 8]);
        end
    endtask : set_filter
    task automatic send_frame(input canf_frame_type f, input logic acc);
        @(posedge clock);
        send <= 1'b1;
        frame_in <= f;
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        #1;
        check_bit("host_valid", acc, host_valid);
        check_bit("reject_pulse", !acc, reject_pulse);
        if (acc) begin
            last_acc = f;
        end
        check_frame("host_frame", last_acc, host_frame);
    endtask : send_frame
    function automatic canf_frame_type std_frame(input logic [31:0] w);
        canf_frame_type f;
        f = '0;
        f.id = {w[31:21], 18'h2AAAA};
        f.rtr = w[20];
        f.dlc = 4'h8;
        f.data = {w[15:0], 48'h1234_5678_9ABC};
        return f;
    endfunction : std_frame
    function automatic canf_frame_type ext_frame(input logic [31:0] w);
        canf_frame_type f;
        f = '0;
        f.ide = 1'b1;
        f.id = w[31:3];
        f.rtr = w[2];
        f.dlc = 4'h2;
        f.data = 64'h0F1E_2D3C_4B5A_6978;
        return f;
    endfunction : ext_frame
    ////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        for (int i = 0; i < 4; i++) begin
            bus_rd_check(`CANF_OFS_CODE0 + 4'(i), `CANF_CODE_RST);
            bus_rd_check(`CANF_OFS_MASK0 + 4'(i), `CANF_MASK_RST);
        end
        bus_rd_check(4'hF, 8'h00);
    endtask : t_reset_values
    task automatic t_accept_all;
        send_frame(std_frame(32'hA5C3_0F96), 1'b1);
        send_frame(ext_frame(32'h5A3C_F069), 1'b1);
    endtask : t_accept_all
    task automatic t_readback;
        set_filter(32'h1357_9BDF, 32'h2468_ACE0);
        for (int i = 0; i < 4; i++) begin
            bus_rd_check(`CANF_OFS_CODE0 + 4'(i), 8'(32'h1357_9BDF >> (24 - 8 * i)));
            bus_rd_check(`CANF_OFS_MASK0 + 4'(i), 8'(32'h2468_ACE0 >> (24 - 8 * i)));
        end
        bus_wr_rd_check(`CANF_OFS_CODE2, 8'h5A);
    endtask : t_readback
    task automatic t_standard(input logic [31:0] c);
        set_filter(c, 32'h0);
        send_frame(std_frame(c), 1'b1);
        for (int i = 0; i < 32; i++) begin
            send_frame(std_frame(c ^ (32'h1 << i)), (i >= 16) && (i <= 19));
        end
    endtask : t_standard
    task automatic t_extended(input logic [31:0] c);
        set_filter(c, 32'h0);
        send_frame(ext_frame(c), 1'b1);
        for (int i = 0; i < 32; i++) begin
            send_frame(ext_frame(c ^ (32'h1 << i)), i < 2);
        end
        set_filter(c, 32'h8000_0000);
        send_frame(ext_frame(c ^ 32'h8000_0000), 1'b1);
        send_frame(ext_frame(c ^ 32'h4000_0000), 1'b0);
    endtask : t_extended
    task automatic t_counters(input logic [31:0] c);
        bus_wr(`CANF_OFS_CTRL, 8'h01);
        bus_wr(`CANF_OFS_ACC_CNT, 8'h55);
        bus_rd_check(`CANF_OFS_ACC_CNT, 8'h00);
        bus_rd_check(`CANF_OFS_REJ_CNT, 8'h00);
        send_frame(ext_frame(c ^ 32'h4), 1'b0);
        bus_rd_check(`CANF_OFS_STAT, 8'h06);
        bus_rd_check(`CANF_OFS_REJ_CNT, 8'h01);
        // Clear lands in the cycle of an accept; the accept must still count
        @(posedge clock);
        send <= 1'b1;
        frame_in <= ext_frame(c);
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
        bus <= '{addr: `CANF_OFS_CTRL, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
        last_acc = ext_frame(c);
        #1;
        check_bit("host_valid", 1'b1, host_valid);
        check_frame("host_frame", last_acc, host_frame);
        @(posedge clock);
        bus.wr <= 1'b0;
        bus_rd_check(`CANF_OFS_ACC_CNT, 8'h01);
        bus_rd_check(`CANF_OFS_REJ_CNT, 8'h00);
        bus_rd_check(`CANF_OFS_STAT, 8'h03);
    endtask : t_counters
    ////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        bus = '0;
        send = 1'b0;
        frame_in = '0;
        last_acc = '0;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        t_reset_values();
        t_accept_all();
        t_readback();
        t_standard(32'h42B0_5AC3);
        t_extended(32'hB4B0_C430);
        t_counters(32'hB4B0_C430);
        report_and_stop();
    end
    initial begin
        #(5000 * 100);
        errors++;
        report_and_stop();
    end
endmodule : can_acceptance_filter_tb
`default_nettype wire
